// >>> bench/ext_mem_model.sv
`timescale 1ns/100ps
module ext_mem_model (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // bus requests and test knobs
   input wire logic i_read_en,
   input wire logic i_hold,
   input wire logic [7:0] i_wait_n,
   // port status
   output logic o_primary_busy,
   output logic o_expansion_busy,
   output logic o_ready
);
   logic [7:0] count;
   logic [7:0] next_count;
   // a slow memory counts the open access before it answers
   always_comb begin
      next_count = i_read_en ? count + 8'h01 : 8'h00;
   end
   always_ff @(posedge i_ref_clk) begin
      count <= i_reset ? 8'h00 : next_count;
   end
   // ready drops as soon as the access is released, never lingers
   assign o_ready = i_read_en && (count >= i_wait_n);
   // busy shows traffic from other masters only; the block tracks its
   // own write, so echoing it here would stall the store on itself
   assign o_primary_busy = i_hold;
   assign o_expansion_busy = i_hold;
endmodule

// >>> bench/mem_pipe_monitor.sv
`timescale 1ns/100ps
module mem_pipe_monitor #(
   parameter int WORD_W = 32,
   parameter int ADDR_W = 16
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // watched outputs
   input wire logic o_first_minor_phase,
   input wire logic o_second_minor_phase,
   input wire logic o_fetch_advance,
   input wire logic o_stall_all,
   input wire logic [WORD_W-1:0] o_read_word,
   input wire logic [WORD_W-1:0] o_exec_word,
   input wire logic o_two_operand,
   input wire logic [ADDR_W-1:0] o_operand_addr,
   input wire logic o_ext_fetch_latch,
   input wire logic o_int_fetch_strobe,
   input wire logic o_ext_fetch_addr_en,
   input wire logic o_int_read_strobe,
   input wire logic o_ext_data_latch,
   input wire logic o_int_store_strobe
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   // exactly one minor phase at a time, three clocks each
   a_phase_exclusive: assert property (
      o_first_minor_phase != o_second_minor_phase)
      else $error("minor phases overlap");
   a_first_len: assert property (
      $rose(o_first_minor_phase) |->
      o_first_minor_phase [*3] ##1 o_second_minor_phase)
      else $error("first phase length wrong");
   a_second_len: assert property (
      $rose(o_second_minor_phase) |->
      o_second_minor_phase [*3] ##1 o_first_minor_phase)
      else $error("second phase length wrong");
   // stage words move only at the close of a major cycle
   a_adv_at_end: assert property (
      o_fetch_advance |-> o_second_minor_phase ##1 o_first_minor_phase)
      else $error("advance outside major end");
   a_stall_blocks: assert property (
      o_stall_all |-> !o_fetch_advance)
      else $error("advance while stalled");
   a_hold_exec: assert property (
      o_stall_all |=> $stable(o_exec_word))
      else $error("execute word moved in a stall");
   // decode of the read-stage word
   a_two_op: assert property (
      o_two_operand == (o_read_word[31:29] inside {3'h0, 3'h2}))
      else $error("two-operand class wrong");
   a_operand_low: assert property (
      o_operand_addr == o_read_word[15:0])
      else $error("operand field wrong");
   // strobe placement inside the major cycle
   a_int_read: assert property (
      o_int_read_strobe |-> o_second_minor_phase)
      else $error("internal read outside second phase");
   a_int_store: assert property (
      o_int_store_strobe |-> o_first_minor_phase)
      else $error("internal store outside first phase");
   a_ext_latch: assert property (
      (o_ext_fetch_latch || o_ext_data_latch) |-> o_second_minor_phase)
      else $error("external latch outside second phase");
   // fetch placement against the phases and a concurrent store
   a_fetch_addr: assert property (
      o_ext_fetch_addr_en |-> o_first_minor_phase)
      else $error("external fetch address outside first phase");
   a_fetch_store_split: assert property (
      o_int_fetch_strobe |-> !o_int_store_strobe)
      else $error("internal fetch shares a phase with a store");
endmodule

bind mem_pipe_ctrl mem_pipe_monitor #(.WORD_W(WORD_W), .ADDR_W(ADDR_W))
   mon_u (.i_ref_clk, .i_reset, .o_first_minor_phase,
   .o_second_minor_phase, .o_fetch_advance, .o_stall_all, .o_read_word,
   .o_exec_word, .o_two_operand, .o_operand_addr, .o_ext_fetch_latch,
   .o_int_read_strobe, .o_ext_data_latch, .o_int_store_strobe,
   .o_int_fetch_strobe, .o_ext_fetch_addr_en);

// >>> bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import mem_pipe_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [31:0] fw = 32'h0, dec, rdw, exw;
   region_e fr = REG_NONE, ra = REG_NONE, rb = REG_NONE, sr = REG_NONE;
   logic call = 1'b0, arw = 1'b0, hold = 1'b0;
   logic [7:0] wait_n = 8'h00;
   logic pb, eb, rdy, ph1, ph2, adv, stall, two, st_en, rd_en;
   logic [15:0] opa;
   int n_errors = 0, compares = 0;

   always #5 i_ref_clk = ~i_ref_clk;

   mem_pipe_ctrl dut_u (.i_ref_clk, .i_reset, .i_fetch_word(fw),
      .i_fetch_region(fr), .i_rd_region_a(ra), .i_rd_region_b(rb),
      .i_st_region(sr), .i_cond_call(call), .i_addr_reg_write(arw),
      .i_primary_busy(pb), .i_expansion_busy(eb), .i_ext_ready(rdy),
      .o_first_minor_phase(ph1), .o_second_minor_phase(ph2),
      .o_fetch_advance(adv), .o_stall_all(stall), .o_decode_word(dec),
      .o_read_word(rdw), .o_exec_word(exw), .o_two_operand(two),
      .o_operand_addr(opa), .o_int_fetch_strobe(), .o_ext_fetch_addr_en(),
      .o_ext_fetch_latch(), .o_int_read_strobe(), .o_ext_read_addr_en(rd_en),
      .o_ext_data_latch(), .o_int_store_strobe(), .o_ext_store_en(st_en));
   ext_mem_model model_u (.i_ref_clk, .i_reset, .i_read_en(rd_en),
      .i_hold(hold), .i_wait_n(wait_n),
      .o_primary_busy(pb), .o_expansion_busy(eb), .o_ready(rdy));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // returns just after the edge that closes a major cycle
   task automatic wait_adv;
      int k;
      k = 0;
      do begin @(negedge i_ref_clk); k++; end
      while (adv !== 1'b1 && k < 80);
      if (adv !== 1'b1) check(1'b0, 1'b1);
      @(posedge i_ref_clk);
   endtask
   task automatic t_phases;
      int n1, n2;
      n1 = 0;
      n2 = 0;
      wait_adv();
      repeat (6) begin
         @(negedge i_ref_clk);
         n1 += int'(ph1 === 1'b1);
         n2 += int'(ph2 === 1'b1);
      end
      check(n1, 3);
      check(n2, 3);
   endtask
   task automatic t_classes;
      logic [31:0] w;
      for (int c = 0; c < 8; c++) begin
         w = {c[2:0], 13'h0a5, 16'h1230 + 16'(c)};
         wait_adv();
         fw <= w;
         wait_adv();
         wait_adv();
         @(negedge i_ref_clk);
         check(rdw, w);
         check(two, (c == 0 || c == 2));
         check(opa, w[15:0]);
      end
   endtask
   // a word fetched alongside data accesses, full rate or not
   task automatic t_mix(input region_e f, a, b, input logic ok);
      logic [31:0] w;
      w = {8'h40, 5'h0, f, a, b, 10'h0};
      wait_adv();
      fw <= w;
      fr <= f;
      ra <= a;
      rb <= b;
      // a short mix never advances, so wait a fixed major cycle
      repeat (6) @(negedge i_ref_clk);
      check(adv, ok);
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      check(dec, ok ? w : NOP_WORD);
      @(posedge i_ref_clk);
      fr <= REG_NONE;
      ra <= REG_NONE;
      rb <= REG_NONE;
   endtask
   task automatic t_busy;
      logic [31:0] e;
      wait_adv();
      ra <= REG_PRIMARY;
      hold <= 1'b1;
      repeat (4) @(negedge i_ref_clk);
      e = exw;
      check(stall, 1'b1);
      repeat (18) @(negedge i_ref_clk);
      check(exw, e);
      @(posedge i_ref_clk);
      hold <= 1'b0;
      wait_adv();
      ra <= REG_NONE;
   endtask
   task automatic t_slow_read;
      logic [31:0] r;
      int k;
      wait_adv();
      ra <= REG_EXPANSION;
      wait_n <= 8'h14;
      @(negedge i_ref_clk);
      r = rdw;
      k = 1;
      while (adv !== 1'b1 && k < 80) begin @(negedge i_ref_clk); k++; end
      // 20 wait clocks and 2 sync flops, held to the fourth major close
      check(k, 24);
      @(posedge i_ref_clk);
      ra <= REG_NONE;
      wait_n <= 8'h00;
      @(negedge i_ref_clk);
      check(exw, r);
   endtask
   task automatic t_store(input region_e s, input int exp);
      int n, a;
      n = 0;
      a = 0;
      wait_adv();
      sr <= s;
      for (int i = 0; i < 24; i++) begin
         @(negedge i_ref_clk);
         n += int'(st_en === 1'b1);
         a += int'(adv === 1'b1);
         // the store lasts one major cycle; drop it at that close
         if (i == 5) begin
            @(posedge i_ref_clk);
            sr <= REG_NONE;
         end
      end
      check(n, exp);
      check(a, 4);
   endtask
   task automatic t_call;
      wait_adv();
      fw <= 32'h0123_4567;
      call <= 1'b1;
      wait_adv();
      call <= 1'b0;
      // the push cycle holds everything up to its close
      repeat (6) @(negedge i_ref_clk);
      check(stall, 1'b1);
      check(adv, 1'b0);
      @(negedge i_ref_clk);
      check(dec, NOP_WORD);
      check(rdw, NOP_WORD);
   endtask
   task automatic t_reg;
      wait_adv();
      arw <= 1'b1;
      wait_adv();
      arw <= 1'b0;
      // one held major cycle, then the pipe runs again
      repeat (6) @(negedge i_ref_clk);
      check(stall, 1'b1);
      check(adv, 1'b0);
      repeat (6) @(negedge i_ref_clk);
      check(adv, 1'b1);
   endtask
   task automatic conclude;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // generous span: the whole sequence needs under 500 cycles
   initial begin
      #200000;
      n_errors++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      t_phases();
      t_classes();
      t_mix(REG_PRIMARY, REG_INT0, REG_NONE, 1'b1);
      t_mix(REG_PRIMARY, REG_EXPANSION, REG_NONE, 1'b1);
      t_mix(REG_INT0, REG_INT0, REG_NONE, 1'b1);
      t_mix(REG_INT1, REG_EXPANSION, REG_NONE, 1'b1);
      t_mix(REG_INT0, REG_INT1, REG_INT2, 1'b1);
      t_mix(REG_INT0, REG_INT0, REG_INT0, 1'b0);
      t_busy();
      t_slow_read();
      t_store(REG_PRIMARY, 12);
      t_store(REG_INT0, 0);
      t_call();
      t_reg();
      conclude();
   end
endmodule

// >>> hdl/mem_pipe_ctrl.sv
`timescale 1ns/100ps
// Contract
// RULE1 - hold all stages while a data access targets a busy external port
// RULE2 - a started multicycle external read runs on, all stages held
// RULE3 - conditional call or trap takes one extra cycle, bubbles upstream
// RULE4 - address register used for data stalls the next memory access
// RULE5 - fetch waits when memory bandwidth cannot serve fetch and data
// RULE6 - four fetch plus one data region mixes run in one cycle
// RULE7 - six fetch plus two data region mixes run in one cycle
// RULE8 - major cycle is two equal minor phases, first then second
// RULE9 - internal fetch in first phase, moved to second by a store
// RULE10 - external fetch drives address at first phase, latches at end
// RULE11 - external read bus cycles equal its execution cycles
// RULE12 - external write uses two bus cycles but one execute cycle
// RULE13 - top bits 000 or 010 mean two-operand; low half is source
// RULE14 - internal read in second phase; external spans the major cycle
// RULE15 - low half is destination; stores begin in the first phase
// RULE16 - stalled stages hold, bubbles go to stages that cannot advance
module mem_pipe_ctrl
   import mem_pipe_pkg::*;
#(
   parameter int WORD_W = 32,
   parameter int ADDR_W = 16
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // fetch side: next instruction word and its region
   input wire logic [WORD_W-1:0] i_fetch_word,
   input wire mem_pipe_pkg::region_e i_fetch_region,
   // read stage: data regions decoded for the instruction in read
   input wire mem_pipe_pkg::region_e i_rd_region_a,
   input wire mem_pipe_pkg::region_e i_rd_region_b,
   // execute stage: stores, conditional call flag, register use
   input wire mem_pipe_pkg::region_e i_st_region,
   input wire logic i_cond_call,
   input wire logic i_addr_reg_write,
   // external ports: busy and data ready (pins, synchronised here)
   input wire logic i_primary_busy,
   input wire logic i_expansion_busy,
   input wire logic i_ext_ready,
   // minor phases
   output logic o_first_minor_phase,
   output logic o_second_minor_phase,
   // stage control
   output logic o_fetch_advance,
   output logic o_stall_all,
   output logic [WORD_W-1:0] o_decode_word,
   output logic [WORD_W-1:0] o_read_word,
   output logic [WORD_W-1:0] o_exec_word,
   output logic o_two_operand,
   output logic [ADDR_W-1:0] o_operand_addr,
   // memory strobes
   output logic o_int_fetch_strobe,
   output logic o_ext_fetch_addr_en,
   output logic o_ext_fetch_latch,
   output logic o_int_read_strobe,
   output logic o_ext_read_addr_en,
   output logic o_ext_data_latch,
   output logic o_int_store_strobe,
   output logic o_ext_store_en
);
   import mem_pipe_pkg::*;

   logic major_end;
   logic [1:0] sync_pb;
   logic [1:0] sync_eb;
   logic [1:0] sync_rdy;
   logic prim_busy;
   logic exp_busy;
   logic ext_rdy;

   // phase generator
   minor_phase_gen u_phase (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .o_first_minor_phase(o_first_minor_phase),
      .o_second_minor_phase(o_second_minor_phase),
      .o_major_start(),
      .o_major_end(major_end)
   );

   // pins cross two flops before any logic sees them
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         sync_pb <= 2'h0;
         sync_eb <= 2'h0;
         sync_rdy <= 2'h0;
      end else begin
         sync_pb <= {sync_pb[0], i_primary_busy};
         sync_eb <= {sync_eb[0], i_expansion_busy};
         sync_rdy <= {sync_rdy[0], i_ext_ready};
      end
   end
   assign prim_busy = sync_pb[1];
   assign exp_busy = sync_eb[1];
   assign ext_rdy = sync_rdy[1];

   // region helpers
   function automatic logic is_int(input region_e r);
      is_int = (r == REG_INT0) || (r == REG_INT1) || (r == REG_INT2);
   endfunction
   function automatic logic is_ext(input region_e r);
      is_ext = (r == REG_PRIMARY) || (r == REG_EXPANSION);
   endfunction

   // count accesses per region for this major cycle
   logic [2:0] use_cnt [0:5];
   logic [2:0] data_cnt [0:5];
   genvar g;
   generate
      for (g = 1; g < 6; g++) begin : g_use
         assign data_cnt[g] =
            3'((i_rd_region_a == region_e'(g)) ? 1 : 0) +
            3'((i_rd_region_b == region_e'(g)) ? 1 : 0) +
            3'((i_st_region == region_e'(g)) ? 1 : 0);
         assign use_cnt[g] = data_cnt[g] +
            3'((i_fetch_region == region_e'(g)) ? 1 : 0);
      end
   endgenerate
   assign use_cnt[0] = 3'h0;
   assign data_cnt[0] = 3'h0;

   // bandwidth check: internal blocks take two, each bus takes one
   logic bw_short;
   always_comb begin
      bw_short = 1'b0;
      for (int k = 1; k < 4; k++) begin
         if (use_cnt[k] > 3'h2) begin
            bw_short = 1'b1;
         end
      end
      if (use_cnt[REG_PRIMARY] > 3'h1 || use_cnt[REG_EXPANSION] > 3'h1) begin
         bw_short = 1'b1; // RULE6 RULE7
      end
   end

   // read and store in flight this major cycle
   logic rd_ext;
   logic st_ext;
   logic port_conflict;
   assign rd_ext = is_ext(i_rd_region_a) || is_ext(i_rd_region_b);
   assign st_ext = is_ext(i_st_region);
   // a data access to a port still busy with an earlier one must retry
   assign port_conflict =
      ((i_rd_region_a == REG_PRIMARY || i_rd_region_b == REG_PRIMARY ||
        i_st_region == REG_PRIMARY) && prim_busy) ||
      ((i_rd_region_a == REG_EXPANSION || i_rd_region_b == REG_EXPANSION ||
        i_st_region == REG_EXPANSION) && exp_busy); // RULE1

   // stall state machine
   typedef enum {ST_RUN, ST_EXT_READ, ST_CALL_PUSH, ST_REG_WAIT} stall_e;
   stall_e state;
   stall_e next_state;
   logic hold_all;
   logic fetch_wait;
   logic call_bubble;

   always_comb begin
      next_state = state;
      hold_all = 1'b0;
      call_bubble = 1'b0;
      case (state)
         ST_RUN: begin
            if (port_conflict) begin
               hold_all = 1'b1; // RULE1
            end else if (major_end && rd_ext && !ext_rdy) begin
               next_state = ST_EXT_READ; // RULE2 RULE11
               hold_all = 1'b1;
            end else if (major_end && i_cond_call) begin
               next_state = ST_CALL_PUSH; // RULE3
            end else if (major_end && i_addr_reg_write) begin
               next_state = ST_REG_WAIT; // RULE4
            end
         end
         ST_EXT_READ: begin
            // once started the read cannot be dropped; one cpu cycle per
            // bus cycle until the data word is latched
            hold_all = 1'b1; // RULE2 RULE11
            if (major_end && ext_rdy) begin
               // word latched at this close, so the stages move on
               next_state = ST_RUN;
               hold_all = 1'b0;
            end
         end
         ST_CALL_PUSH: begin
            // extra cycle pushes the return address, upstream gets nops
            hold_all = 1'b1; // RULE3
            call_bubble = 1'b1; // RULE3
            if (major_end) begin
               next_state = ST_RUN;
            end
         end
         ST_REG_WAIT: begin
            // new register value not yet usable for the next access
            hold_all = 1'b1; // RULE4
            if (major_end) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // fetch waits for the data accesses when bandwidth is short
   assign fetch_wait = bw_short && !hold_all; // RULE5

   // pipeline registers
   logic [WORD_W-1:0] dec_q;
   logic [WORD_W-1:0] rd_q;
   logic [WORD_W-1:0] ex_q;
   logic [WORD_W-1:0] next_dec;
   logic [WORD_W-1:0] next_rd;
   logic [WORD_W-1:0] next_ex;

   always_comb begin
      next_dec = dec_q;
      next_rd = rd_q;
      next_ex = ex_q;
      if (major_end) begin
         if (call_bubble) begin
            next_dec = NOP_WORD; // RULE3 RULE16
            next_rd = NOP_WORD;
         end else if (hold_all) begin
            // all stages keep their instructions; nothing advances
            next_ex = ex_q; // RULE16
         end else if (fetch_wait) begin
            // decode cannot get a word, so a bubble moves down
            next_dec = NOP_WORD; // RULE5 RULE16
            next_rd = dec_q;
            next_ex = rd_q;
         end else begin
            next_dec = i_fetch_word;
            next_rd = dec_q;
            next_ex = rd_q;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         dec_q <= NOP_WORD;
         rd_q <= NOP_WORD;
         ex_q <= NOP_WORD;
      end else begin
         dec_q <= next_dec;
         rd_q <= next_rd;
         ex_q <= next_ex;
      end
   end

   assign o_decode_word = dec_q;
   assign o_read_word = rd_q;
   assign o_exec_word = ex_q;
   assign o_stall_all = hold_all;
   assign o_fetch_advance = major_end && !hold_all && !fetch_wait;

   // two-operand decode on the read stage word
   assign o_two_operand = (rd_q[CLASS_HI:CLASS_LO] == CLASS_TWO_OP_A) ||
                          (rd_q[CLASS_HI:CLASS_LO] == CLASS_TWO_OP_B); // RULE13
   // low half is source for a read, destination for a store
   assign o_operand_addr = ADDR_W'(rd_q[OPERAND_HI:OPERAND_LO]); // RULE13 RULE15

   // external write: the port keeps two bus cycles, cpu moves on
   logic [1:0] wr_bus_cnt;
   logic [1:0] next_wr_bus_cnt;
   always_comb begin
      next_wr_bus_cnt = wr_bus_cnt;
      if (major_end) begin
         if (st_ext && !port_conflict) begin
            next_wr_bus_cnt = 2'(WRITE_BUS_CYCLES - 1); // RULE12
         end else if (wr_bus_cnt != 2'h0) begin
            next_wr_bus_cnt = wr_bus_cnt - 2'h1;
         end
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         wr_bus_cnt <= 2'h0;
      end else begin
         wr_bus_cnt <= next_wr_bus_cnt;
      end
   end

   // phase placement of strobes; a store steals the first phase
   logic store_int;
   logic run;
   assign store_int = is_int(i_st_region) && !hold_all;
   assign run = !hold_all && !fetch_wait;
   assign o_int_fetch_strobe = run && is_int(i_fetch_region) &&
      (store_int ? o_second_minor_phase : o_first_minor_phase); // RULE9
   assign o_ext_fetch_addr_en = run && is_ext(i_fetch_region) &&
                                o_first_minor_phase; // RULE10
   assign o_ext_fetch_latch = run && is_ext(i_fetch_region) &&
                              major_end; // RULE10
   assign o_int_read_strobe = o_two_operand && !hold_all &&
      (is_int(i_rd_region_a) || is_int(i_rd_region_b)) &&
      o_second_minor_phase; // RULE14
   // address stands from the first phase until the word is latched
   assign o_ext_read_addr_en = rd_ext && !port_conflict; // RULE14
   assign o_ext_data_latch = rd_ext && major_end && ext_rdy &&
                             !port_conflict; // RULE14 RULE2
   assign o_int_store_strobe = store_int && o_first_minor_phase; // RULE15
   // bus keeps address and data from the first phase for two bus cycles
   assign o_ext_store_en = (st_ext && !port_conflict && !hold_all) ||
      (wr_bus_cnt != 2'h0); // RULE15 RULE12
endmodule

// >>> hdl/mem_pipe_pkg.sv
package mem_pipe_pkg;
   // memory region codes for an access
   typedef enum logic [2:0] {
      REG_NONE,
      REG_INT0,
      REG_INT1,
      REG_INT2,
      REG_PRIMARY,
      REG_EXPANSION
   } region_e;

   // instruction word layout
   localparam int CLASS_HI = 31;
   localparam int CLASS_LO = 29;
   localparam logic [2:0] CLASS_TWO_OP_A = 3'h0;
   localparam logic [2:0] CLASS_TWO_OP_B = 3'h2;
   localparam int OPERAND_HI = 15;
   localparam int OPERAND_LO = 0;
   localparam logic [31:0] NOP_WORD = 32'h0c80_0000;

   // clocking: one major period made of two minor phases
   localparam int CLK_PERIOD_NS = 10;
   localparam int MAJOR_PERIOD_NS = 60;
   localparam int MINOR_PERIOD_NS = 30;
   localparam int MINOR_CYCLES = (MINOR_PERIOD_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int PHASE_CNT_W = 3;
   localparam logic [PHASE_CNT_W-1:0] PHASE_CNT_RESET = 3'h0;

   // least bus cycles for an external write
   localparam int WRITE_BUS_CYCLES = 2;
endpackage

// >>> hdl/minor_phase_gen.sv
`timescale 1ns/100ps
// splits the core clock into two equal minor phases per major cycle
module minor_phase_gen
   import mem_pipe_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // phase outputs
   output logic o_first_minor_phase,
   output logic o_second_minor_phase,
   output logic o_major_start,
   output logic o_major_end
);
   logic [PHASE_CNT_W-1:0] cnt;
   logic [PHASE_CNT_W-1:0] next_cnt;
   logic second;
   logic next_second;

   // count clocks inside a minor phase, flip phase at its end
   always_comb begin
      next_cnt = cnt + 3'h1;
      next_second = second;
      if (cnt == PHASE_CNT_W'(MINOR_CYCLES - 1)) begin
         next_cnt = PHASE_CNT_RESET;
         next_second = ~second;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         cnt <= PHASE_CNT_RESET;
         second <= 1'b0;
      end else begin
         cnt <= next_cnt;
         second <= next_second;
      end
   end

   // phases high while active, first then second
   assign o_first_minor_phase = ~second; // RULE8
   assign o_second_minor_phase = second; // RULE8
   assign o_major_start = ~second && (cnt == PHASE_CNT_RESET);
   assign o_major_end = second && (cnt == PHASE_CNT_W'(MINOR_CYCLES - 1));
endmodule
